// [rtl/phy_basic_mode_control.v]
// Management registers of one Ethernet PHY port behind AXI4-Lite.
// Assumes straps and event inputs are synchronous to clk.
//
// The implementer's own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`include "phy_mode_defines.vh"

module phy_basic_mode_control
#(
    parameter [15:0] LOOPBACK_SETTLE_CYCLES = `LOOPBACK_DEAD_CYCLES
)
(
    input wire clk,
    input wire resetn,
    input wire ce,
    // AXI4-Lite slave
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // Strap levels
    input wire strap_speed_100,
    input wire strap_full_duplex,
    input wire strap_aneg_enable,
    // Auto-negotiation outcome
    input wire aneg_speed_100,
    input wire aneg_full_duplex,
    // Event sources of the status fields
    input wire evt_active,
    input wire evt_pulse,
    input wire cond_low_event_n,
    input wire cond_high_event,
    // Port control
    output reg port_reset_q,
    output reg loopback_q,
    output reg loopback_settling_q,
    output reg aneg_enable_q,
    output reg link_speed_100_q,
    output reg link_full_duplex_q
);

    localparam [1:0] SEL_BMC = 2'h0;
    localparam [1:0] SEL_EVT = 2'h1;
    localparam [1:0] SEL_MODE = 2'h2;
    localparam [1:0] SEL_NONE = 2'h3;
    localparam integer SW_RESET_LEN = `SW_RESET_CYCLES;

    // Shared by the write and read decoders
    function [1:0] reg_sel;
        input [7:0] addr;
        begin
            if (addr[7:2] == `OFS_BASIC_MODE_CONTROL >> 2)
                reg_sel = SEL_BMC;
            else if (addr[7:2] == `OFS_EVENT_STATUS >> 2)
                reg_sel = SEL_EVT;
            else if (addr[7:2] == `OFS_MODE_STATUS >> 2)
                reg_sel = SEL_MODE;
            else
                reg_sel = SEL_NONE;
        end
    endfunction

    reg speed_q;
    reg duplex_q;
    reg strap_load_q;
    reg [3:0] sw_reset_cnt_q;
    reg [15:0] settle_cnt_q;
    reg aw_have_q;
    reg w_have_q;
    reg [7:0] awaddr_q;
    reg [31:0] wdata_q;
    reg [3:0] wstrb_q;
    wire [3:0] field_in;
    wire [3:0] field_val;
    wire ar_take;
    wire evt_rd_clear;
    wire wr_do;
    wire wr_bmc;
    wire [15:0] bmc_rd;
    wire [15:0] evt_rd;
    wire [15:0] mode_rd;

    assign ar_take = ce & s_axi_arvalid & s_axi_arready;
    // Clear happens on the same edge that captures the read value
    assign evt_rd_clear = ar_take & (reg_sel(s_axi_araddr) == SEL_EVT);
    assign wr_do = aw_have_q & w_have_q & ~s_axi_bvalid;
    assign wr_bmc = wr_do & (reg_sel(awaddr_q) == SEL_BMC) & wstrb_q[1];

    assign field_in[`EVT_SELF_CLEARING] = evt_active;
    assign field_in[`EVT_CLEAR_ON_READ] = evt_pulse;
    assign field_in[`EVT_LATCHED_LOW] = cond_low_event_n;
    assign field_in[`EVT_LATCHED_HIGH] = cond_high_event;

    genvar gi;
    generate
        for (gi = 0; gi < `EVT_FIELD_COUNT; gi = gi + 1)
        begin : g_field
            localparam [31:0] KIND_I = gi;
            status_field
            #(
                .KIND(KIND_I[1:0])
            )
            u_field
            (
                .clk(clk),
                .resetn(resetn),
                .ce(ce),
                .cond(field_in[gi]),
                .rd_clear(evt_rd_clear),
                .value_q(field_val[gi])
            );
        end
    endgenerate

    // Bits 11:9, 7 and 6:0 are outside this block and read as zero
    assign bmc_rd = {port_reset_q, loopback_q, speed_q, aneg_enable_q,
                     3'h0, duplex_q, 8'h00};
    // The fixed byte is built from a constant, so no write reaches it
    assign evt_rd = {`PERM_RO_VALUE, 4'h0, field_val};
    assign mode_rd = {12'h000, loopback_settling_q, port_reset_q,
                      link_speed_100_q, link_full_duplex_q};

    // Basic mode control fields and software reset
    always @(posedge clk)
    begin
        if (!resetn)
        begin
            port_reset_q <= `BMC_SW_RESET_RST;
            loopback_q <= `BMC_LOOPBACK_RST;
            speed_q <= 1'b0;
            duplex_q <= 1'b0;
            aneg_enable_q <= 1'b0;
            strap_load_q <= 1'b1;
            sw_reset_cnt_q <= 4'h0;
        end
        else if (ce)
        begin
            if (strap_load_q)
            begin
                // Straps are caught after reset release, never under it
                speed_q <= strap_speed_100;
                duplex_q <= strap_full_duplex;
                aneg_enable_q <= strap_aneg_enable;
                strap_load_q <= 1'b0;
            end
            else if (port_reset_q)
            begin
                // Control writes are ignored until the reset finishes
                if (sw_reset_cnt_q == 4'h1)
                begin
                    port_reset_q <= 1'b0;
                    loopback_q <= `BMC_LOOPBACK_RST;
                    strap_load_q <= 1'b1;
                end
                sw_reset_cnt_q <= sw_reset_cnt_q - 4'h1;
            end
            else if (wr_bmc)
            begin
                if (wdata_q[`BMC_SW_RESET])
                begin
                    port_reset_q <= 1'b1;
                    sw_reset_cnt_q <= SW_RESET_LEN[3:0];
                end
                loopback_q <= wdata_q[`BMC_LOOPBACK];
                speed_q <= wdata_q[`BMC_SPEED_100];
                aneg_enable_q <= wdata_q[`BMC_ANEG_ENABLE];
                duplex_q <= wdata_q[`BMC_FULL_DUPLEX];
            end
        end
    end

    // Dead time after loopback is turned on
    always @(posedge clk)
    begin
        if (!resetn)
        begin
            settle_cnt_q <= 16'h0000;
            loopback_settling_q <= 1'b0;
        end
        else if (ce)
        begin
            if (!loopback_q)
            begin
                settle_cnt_q <= LOOPBACK_SETTLE_CYCLES;
                loopback_settling_q <= 1'b0;
            end
            else if (settle_cnt_q != 16'h0000)
            begin
                settle_cnt_q <= settle_cnt_q - 16'h0001;
                loopback_settling_q <= 1'b1;
            end
            else
            begin
                loopback_settling_q <= 1'b0;
            end
        end
    end

    // Link mode in use
    always @(posedge clk)
    begin
        if (!resetn)
        begin
            link_speed_100_q <= 1'b0;
            link_full_duplex_q <= 1'b0;
        end
        else if (ce)
        begin
            if (aneg_enable_q)
            begin
                link_speed_100_q <= aneg_speed_100;
                link_full_duplex_q <= aneg_full_duplex;
            end
            else
            begin
                link_speed_100_q <= speed_q;
                link_full_duplex_q <= duplex_q;
            end
        end
    end

    // Write channels: address and data may come in either order
    always @(posedge clk)
    begin
        if (!resetn)
        begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RESP_OKAY;
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            awaddr_q <= 8'h00;
            wdata_q <= 32'h00000000;
            wstrb_q <= 4'h0;
        end
        else if (ce)
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                awaddr_q <= s_axi_awaddr;
                aw_have_q <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
                w_have_q <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (wr_do)
            begin
                aw_have_q <= 1'b0;
                w_have_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                // Read-only registers accept and drop the data
                if (reg_sel(awaddr_q) == SEL_NONE)
                    s_axi_bresp <= `RESP_SLVERR;
                else
                    s_axi_bresp <= `RESP_OKAY;
            end
            if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // Read channel: one read at a time, data one cycle after address
    always @(posedge clk)
    begin
        if (!resetn)
        begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `RESP_OKAY;
        end
        else if (ce)
        begin
            if (ar_take)
            begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= `RESP_OKAY;
                if (reg_sel(s_axi_araddr) == SEL_BMC)
                    s_axi_rdata <= {16'h0000, bmc_rd};
                else if (reg_sel(s_axi_araddr) == SEL_EVT)
                    s_axi_rdata <= {16'h0000, evt_rd};
                else if (reg_sel(s_axi_araddr) == SEL_MODE)
                    s_axi_rdata <= {16'h0000, mode_rd};
                else
                begin
                    s_axi_rdata <= 32'h00000000;
                    s_axi_rresp <= `RESP_SLVERR;
                end
            end
            else if (s_axi_rvalid && s_axi_rready)
            begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

endmodule // phy_basic_mode_control

// [rtl/phy_mode_defines.vh]
// Constants for the port management register block: offsets, bit
// positions, reset values, access kinds and timing counts.
// Assumes a 10 MHz clock and a 32-bit AXI4-Lite register bus.
`ifndef PHY_MODE_DEFINES_VH
`define PHY_MODE_DEFINES_VH

// Byte offsets of the registers
`define OFS_BASIC_MODE_CONTROL 8'h00
`define OFS_EVENT_STATUS 8'h04
`define OFS_MODE_STATUS 8'h08

// Basic mode control bit positions
`define BMC_SW_RESET 15
`define BMC_LOOPBACK 14
`define BMC_SPEED_100 13
`define BMC_ANEG_ENABLE 12
`define BMC_FULL_DUPLEX 8

// Reset values of the non-strap control bits
`define BMC_SW_RESET_RST 1'b0
`define BMC_LOOPBACK_RST 1'b0

// Event status layout: bits 3:0 are field cells, 15:8 fixed value
`define EVT_SELF_CLEARING 0
`define EVT_CLEAR_ON_READ 1
`define EVT_LATCHED_LOW 2
`define EVT_LATCHED_HIGH 3
`define EVT_FIELD_COUNT 4
`define EVT_PERM_LSB 8
// Arbitrary fixed pattern for the permanent read-only byte
`define PERM_RO_VALUE 8'h5A

// Access kinds of a status field cell
`define KIND_SELF_CLEARING 2'h0
`define KIND_CLEAR_ON_READ 2'h1
`define KIND_LATCHED_LOW 2'h2
`define KIND_LATCHED_HIGH 2'h3

// AXI responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

// Timing
`define CLK_PERIOD_NS 100
`define SW_RESET_TIME_NS 1000
`define SW_RESET_CYCLES ((`SW_RESET_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define LOOPBACK_DEAD_US 500
`define LOOPBACK_DEAD_CYCLES ((`LOOPBACK_DEAD_US * 1000) / `CLK_PERIOD_NS)

`endif

// [rtl/status_field.v]
// One management status bit with a selectable access kind.
// Assumes rd_clear pulses for one cycle on a read of its register.
`timescale 1ns/100ps
`include "phy_mode_defines.vh"

module status_field
#(
    parameter [1:0] KIND = `KIND_SELF_CLEARING
)
(
    input wire clk,
    input wire resetn,
    input wire ce,
    input wire cond,
    input wire rd_clear,
    output reg value_q
);

    always @(posedge clk)
    begin
        if (!resetn)
        begin
            value_q <= 1'b0;
        end
        else if (ce)
        begin
            case (KIND)
                `KIND_SELF_CLEARING:
                begin
                    // Follows the event: set while it lasts
                    value_q <= cond;
                end
                `KIND_CLEAR_ON_READ:
                begin
                    // A new event in the read cycle wins over the clear
                    if (cond)
                        value_q <= 1'b1;
                    else if (rd_clear)
                        value_q <= 1'b0;
                end
                `KIND_LATCHED_LOW:
                begin
                    if (!cond)
                        value_q <= 1'b0;
                    else if (rd_clear)
                        value_q <= 1'b1;
                end
                default:
                begin
                    if (cond)
                        value_q <= 1'b1;
                    else if (rd_clear)
                        value_q <= 1'b0;
                end
            endcase
        end
    end

endmodule // status_field

// [verif/phy_basic_mode_control_properties.sv]
// Checker for the port management register block, bound to its top.
// Assumes one clock and ce held high while a dead time or reset runs.
`timescale 1ns/100ps

module phy_mode_checker
#(
    parameter [15:0] LOOPBACK_SETTLE_CYCLES = 16'h1388
)
(
    input wire clk,
    input wire resetn,
    input wire ce,
    input wire [31:0] s_axi_rdata,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire strap_aneg_enable,
    input wire aneg_speed_100,
    input wire aneg_full_duplex,
    input wire port_reset_q,
    input wire loopback_q,
    input wire loopback_settling_q,
    input wire aneg_enable_q,
    input wire link_speed_100_q,
    input wire link_full_duplex_q
);
    // Length of the dead time run so far; a fixed repeat cannot reach it
    reg [15:0] run_q = 16'h0000;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    always @(posedge clk)
        run_q <= loopback_settling_q ? run_q + 16'h0001 : 16'h0000;

    a_read_stands: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer dropped early");
    a_reset_time: assert property ($rose(port_reset_q) |->
        port_reset_q [*8] ##1 port_reset_q [*2] ##1 !port_reset_q)
        else $error("software reset length wrong");
    a_reset_reload: assert property ($fell(port_reset_q) |=>
        aneg_enable_q == strap_aneg_enable)
        else $error("strap value not reloaded");
    a_settle_len: assert property (
        $fell(loopback_settling_q) && loopback_q |->
        run_q == LOOPBACK_SETTLE_CYCLES)
        else $error("dead time length wrong");
    a_settle_start: assert property ($rose(loopback_q) |=>
        loopback_settling_q && loopback_q)
        else $error("dead time did not start");
    a_settle_drop: assert property (!loopback_q |=>
        !loopback_settling_q)
        else $error("dead time outlived loopback");
    a_aneg_follow: assert property (aneg_enable_q && ce |=>
        link_speed_100_q == $past(aneg_speed_100) &&
        link_full_duplex_q == $past(aneg_full_duplex))
        else $error("link mode not from negotiation");
    a_reset_clears: assert property (disable iff (1'b0)
        !resetn && ce |=> !port_reset_q && !loopback_q && !s_axi_rvalid)
        else $error("reset left state behind");

    c_soft_reset: cover property ($rose(port_reset_q));
    c_dead_time: cover property ($fell(loopback_settling_q));
    c_read_done: cover property (s_axi_rvalid && s_axi_rready);
endmodule // phy_mode_checker

bind phy_basic_mode_control phy_mode_checker
    #(.LOOPBACK_SETTLE_CYCLES(LOOPBACK_SETTLE_CYCLES)) chk_u
(
    .clk(clk), .resetn(resetn), .ce(ce), .s_axi_rdata(s_axi_rdata),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .strap_aneg_enable(strap_aneg_enable), .aneg_speed_100(aneg_speed_100),
    .aneg_full_duplex(aneg_full_duplex), .port_reset_q(port_reset_q),
    .loopback_q(loopback_q), .loopback_settling_q(loopback_settling_q),
    .aneg_enable_q(aneg_enable_q), .link_speed_100_q(link_speed_100_q),
    .link_full_duplex_q(link_full_duplex_q)
);

// [verif/axil_master.sv]
// Station model: AXI4-Lite master, one access at a time.
// Assumes ce is high while it works; every wait is bounded.
`timescale 1ns/100ps

module axil_master
(
    input wire clk,
    output reg [7:0] awaddr = 8'h00,
    output reg awvalid = 1'b0,
    input wire awready,
    output reg [31:0] wdata = 32'h00000000,
    output reg [3:0] wstrb = 4'h0,
    output reg wvalid = 1'b0,
    input wire wready,
    input wire [1:0] bresp,
    input wire bvalid,
    output reg bready = 1'b0,
    output reg [7:0] araddr = 8'h00,
    output reg arvalid = 1'b0,
    input wire arready,
    input wire [31:0] rdata,
    input wire [1:0] rresp,
    input wire rvalid,
    output reg rready = 1'b0
);
    // Cycles held back before taking an answer, to act as a slow station
    integer lag = 0;
    reg hung = 1'b0;
    // Response of the last write, kept for the bench to compare
    reg [1:0] bresp_seen = 2'h0;

    task wr(input [7:0] a, input [31:0] d, input [3:0] s);
        integer n;
        begin
            awaddr <= a;
            wdata <= d;
            wstrb <= s;
            awvalid <= 1'b1;
            wvalid <= 1'b1;
            n = 0;
            do
            begin
                @(posedge clk);
                n = n + 1;
                if (awready)
                    awvalid <= 1'b0;
                if (wready)
                    wvalid <= 1'b0;
            end while ((awvalid && !awready || wvalid && !wready) && n < 50);
            repeat (lag) @(posedge clk);
            bready <= 1'b1;
            do
            begin
                @(posedge clk);
                n = n + 1;
            end while (!bvalid && n < 100);
            bresp_seen = bresp;
            bready <= 1'b0;
            if (n >= 100)
                hung = 1'b1;
        end
    endtask

    task rd(input [7:0] a, output [31:0] d, output [1:0] r);
        integer n;
        begin
            araddr <= a;
            arvalid <= 1'b1;
            n = 0;
            do
            begin
                @(posedge clk);
                n = n + 1;
            end while (!arready && n < 50);
            arvalid <= 1'b0;
            repeat (lag) @(posedge clk);
            rready <= 1'b1;
            do
            begin
                @(posedge clk);
                n = n + 1;
            end while (!rvalid && n < 100);
            rready <= 1'b0;
            d = rdata;
            r = rresp;
            if (n >= 100)
                hung = 1'b1;
        end
    endtask
endmodule // axil_master

// [verif/phy_basic_mode_control_tb.sv]
// Bench for the port management register block with a station model.
// Assumes a 10 MHz clock; the dead time is cut to 20 cycles.
`timescale 1ns/100ps
`include "phy_mode_defines.vh"

module phy_basic_mode_control_tb;
    localparam [15:0] SETTLE = 16'h0014;
    // Columns: data written, control read back, mode status read back
    reg [35:0] rows [0:3] = '{36'h000000000, 36'h210021003,
        36'h20FF20002, 36'h300030001};
    // Event status while each field kind holds its event
    localparam [63:0] HELD = {16'h5A0C, 16'h5A00, 16'h5A06, 16'h5A05};
    reg clk = 1'b0;
    reg resetn = 1'b0;
    reg ce = 1'b1;
    reg [3:0] ev = 4'h0;
    // Strap levels: speed, duplex, auto-negotiation enable
    reg [2:0] strap = 3'h5;
    wire [1:0] bresp;
    integer err_total = 0;
    integer samples_checked = 0;
    integer i;
    reg [31:0] rd_data;
    reg [1:0] rd_resp;
    wire [7:0] awaddr, araddr;
    wire [31:0] wdata, rdata;
    wire [3:0] wstrb;
    wire [1:0] rresp;
    wire awvalid, awready, wvalid, wready, bvalid, bready;
    wire arvalid, arready, rvalid, rready, port_reset_q, loopback_q;

    initial
    begin
        forever #50 clk = ~clk;
    end

    axil_master mst_u
    (
        .clk(clk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata),
        .rresp(rresp), .rvalid(rvalid), .rready(rready)
    );

    phy_basic_mode_control #(.LOOPBACK_SETTLE_CYCLES(SETTLE)) dut_u
    (
        .clk(clk), .resetn(resetn), .ce(ce), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .strap_speed_100(strap[2]),
        .strap_full_duplex(strap[1]), .strap_aneg_enable(strap[0]),
        .aneg_speed_100(1'b0), .aneg_full_duplex(1'b1),
        .evt_active(ev[0]), .evt_pulse(ev[1]), .cond_low_event_n(~ev[2]),
        .cond_high_event(ev[3]), .port_reset_q(port_reset_q),
        .loopback_q(loopback_q), .loopback_settling_q(),
        .aneg_enable_q(), .link_speed_100_q(), .link_full_duplex_q()
    );

    task chk(input string nm, input [31:0] got, input [31:0] exp);
        begin
            samples_checked = samples_checked + 1;
            if (got !== exp)
            begin
                err_total = err_total + 1;
                $display("wrong value %s expected %h seen %h", nm, exp, got);
            end
        end
    endtask

    task rdchk(input string nm, input [7:0] a, input [31:0] exp);
        begin
            mst_u.rd(a, rd_data, rd_resp);
            chk(nm, rd_data, exp);
        end
    endtask

    task tally_and_finish;
        begin
            if (mst_u.hung)
                err_total = err_total + 1;
            if (err_total == 0 && samples_checked > 0)
                $display("Test passed");
            else
                $display("Test failed");
            $finish;
        end
    endtask

    initial
    begin
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        repeat (3) @(posedge clk);
        rdchk("control at reset", 8'h00, 32'h00003000);
        rdchk("mode at reset", 8'h08, 32'h00000001);
        for (i = 0; i < 4; i = i + 1)
        begin
            mst_u.wr(8'h00, {16'h0000, rows[i][35:20]}, 4'hF);
            rdchk("control", 8'h00, {16'h0, rows[i][19:4]});
            rdchk("mode", 8'h08, {28'h0, rows[i][3:0]});
        end
        mst_u.wr(8'h00, 32'h00004000, 4'hF);
        chk("loopback", {31'h0, loopback_q}, 32'h00000001);
        rdchk("dead time", 8'h08, 32'h00000008);
        repeat (25) @(posedge clk);
        rdchk("dead time over", 8'h08, 32'h00000000);
        // New strap levels, so the reload is told apart from power-up
        strap <= 3'h3;
        mst_u.wr(8'h00, 32'h00008100, 4'hF);
        chk("reset running", {31'h0, port_reset_q}, 32'h00000001);
        rdchk("control in reset", 8'h00, 32'h00008100);
        repeat (12) @(posedge clk);
        rdchk("control restored", 8'h00, 32'h00001100);
        mst_u.wr(8'h00, 32'h00004000, 4'hD);
        rdchk("byte 1 not strobed", 8'h00, 32'h00001100);
        mst_u.lag = 2;
        rdchk("events at start", 8'h04, 32'h00005A00);
        for (i = 0; i < 4; i = i + 1)
        begin
            ev <= 4'h1 << i;
            @(posedge clk);
            if (i != 0)
                ev <= 4'h0;
            repeat (2) @(posedge clk);
            rdchk("held", 8'h04, {16'h0, HELD[i*16 +: 16]});
            ev <= 4'h0;
            repeat (2) @(posedge clk);
            rdchk("gone", 8'h04, 32'h00005A04);
        end
        mst_u.wr(8'h04, 32'hFFFFFFFF, 4'hF);
        chk("ro write resp", {30'h0, mst_u.bresp_seen},
            {30'h0, `RESP_OKAY});
        rdchk("fixed byte", 8'h04, 32'h00005A04);
        rdchk("unmapped", 8'h0C, 32'h00000000);
        chk("unmapped resp", {30'h0, rd_resp}, {30'h0, `RESP_SLVERR});
        mst_u.wr(8'h0C, 32'hFFFFFFFF, 4'hF);
        chk("unmapped write resp", {30'h0, mst_u.bresp_seen},
            {30'h0, `RESP_SLVERR});
        ce <= 1'b0;
        repeat (3) @(posedge clk);
        ce <= 1'b1;
        rdchk("after hold", 8'h00, 32'h00001100);
        // Reset in mid-run: straps reloaded, field cells back to zero
        resetn <= 1'b0;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        repeat (3) @(posedge clk);
        rdchk("control after reset", 8'h00, 32'h00001100);
        rdchk("events after reset", 8'h04, 32'h00005A00);
        tally_and_finish;
    end
endmodule // phy_basic_mode_control_tb
